// File: core/piw_ctrl.v
/*
 * prioritised interrupt and wake controller for a small 8-bit core.
 * holds enable, priority and port1 wake registers on the core special
 * register port, captures flags, arbitrates four levels with nesting and
 * hands a vector to the core.
 * assumes peripherals give one-cycle set pulses synchronous to core_clk_in,
 * pins are asynchronous, and the core pulses ack on vector fetch and
 * reti_in on return from service.
 */
`include "piw_consts.vh"

// Overview of operation
// RULE1: twelve sources, four priority levels
// RULE2: events set flags regardless of enables
// RULE3: enabled irq ends idle; pins end stop
// RULE4: fixed vectors spaced eight apart
// RULE5: slot between timer2 and timer3 reserved
// RULE6: grant when no equal-or-higher service active
// RULE7: equal-or-higher service holds new request pending
// RULE8: higher level preempts; lower resumes afterwards
// RULE9: per-pin port1 wake and change mask
// RULE10: global enable zero blocks all servicing
// RULE11: pin enables also give stop wake
// RULE12: port1 change enable gates servicing only
// RULE13: first enable register bit layout
// RULE14: second enable register bit layout
// RULE15: high and low bits form level
// RULE16: first priority pair bit layout
// RULE17: second priority pair bit layout
// RULE18: equal levels: lowest vector first
// RULE19: pin edge flags clear on service entry
// RULE20: idle wake needs source and global enable
// RULE21: aux flags: write zero clears, one keeps
module piw_ctrl (
   input wire core_clk_in,
   input wire reset_in,
   // special register port from the core
   input wire [7:0] sfr_addr_in,
   input wire sfr_wr_in,
   input wire [7:0] sfr_wdata_in,
   output reg [7:0] sfr_rdata_out,
   // pins
   input wire ext_pin0_in,
   input wire ext_pin1_in,
   input wire ext_pin2_in,
   input wire [7:0] port1_pins_in,
   // pin trigger type, 1 falling edge, 0 low level
   input wire pin0_edge_mode_in,
   input wire pin1_edge_mode_in,
   // combined peripheral flag levels, owned and cleared by the peripherals
   input wire timer0_overflow_flag_in,
   input wire timer1_overflow_flag_in,
   input wire uart1_flag_in,
   input wire timer2_flag_in,
   input wire spi_flag_in,
   input wire uart2_flag_in,
   // one-cycle set pulses for flags held here
   input wire timer3_overflow_set_in,
   input wire adc_done_set_in,
   input wire touch_done_set_in,
   // core handshake
   input wire irq_ack_in,
   input wire reti_in,
   output reg irq_req_out,
   output reg [15:0] irq_vector_out,
   output reg idle_wake_out,
   output reg stop_wake_out,
   output reg pin0_edge_flag_out,
   output reg pin1_edge_flag_out
);

   // ========================================================================
   // registers
   reg [7:0] port1_wake_mask_q; // RULE9
   reg [7:0] ien0_q; // RULE13
   reg [7:0] ien1_q; // RULE14
   reg [7:0] prl0_q; // low priority bits, first
   reg [7:0] prh0_q; // high priority bits, first
   reg [7:0] prl1_q; // low priority bits, second
   reg [7:0] prh1_q; // high priority bits, second
   reg [7:0] aux_q; // aux flag register
   reg [3:0] active_q; // one bit per level in service
   reg [3:0] slot_q; // slot handed to the core

   // ========================================================================
   // vector arithmetic used for the vector output
   function [15:0] slot_vec;
      input [3:0] slot;
      begin
         slot_vec = `PIW_VEC_BASE + {9'h000, slot, 3'h0}; // RULE4
      end
   endfunction

   // write strobe decode shared by all registers
   function wr_hit;
      input [7:0] addr;
      begin
         wr_hit = sfr_wr_in && (sfr_addr_in == addr);
      end
   endfunction

   // ========================================================================
   // pin synchronisers
   wire p0_lvl;
   wire p0_fall;
   wire p1_lvl;
   wire p1_fall;
   wire p2_fall;
   wire [7:0] p1_chg;

   piw_edge_sync u_p0 (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .pin_in(ext_pin0_in),
      .level_out(p0_lvl),
      .fall_out(p0_fall),
      .change_out()
   );
   piw_edge_sync u_p1 (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .pin_in(ext_pin1_in),
      .level_out(p1_lvl),
      .fall_out(p1_fall),
      .change_out()
   );
   piw_edge_sync u_p2 (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .pin_in(ext_pin2_in),
      .level_out(),
      .fall_out(p2_fall),
      .change_out()
   );

   // port1 stages start high; a low pin shows one false
   // change after reset, harmless as the mask resets to zero
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gen_port1
         piw_edge_sync u_pc (
            .core_clk_in(core_clk_in),
            .reset_in(reset_in),
            .pin_in(port1_pins_in[g]),
            .level_out(),
            .fall_out(),
            .change_out(p1_chg[g])
         );
      end
   endgenerate

   // ========================================================================
   // source request vector and levels
   wire [12:0] flags;
   wire [12:0] enables;
   wire [25:0] levels;
   wire [12:0] gated;
   wire ack_take;
   wire p1_change_hit;

   // level-mode pins request while low, edge mode uses the latched flag
   assign flags[0] = pin0_edge_mode_in ? pin0_edge_flag_out : ~p0_lvl;
   assign flags[1] = timer0_overflow_flag_in;
   assign flags[2] = pin1_edge_mode_in ? pin1_edge_flag_out : ~p1_lvl;
   assign flags[3] = timer1_overflow_flag_in;
   assign flags[4] = uart1_flag_in;
   assign flags[5] = timer2_flag_in;
   assign flags[6] = 1'b0; // RULE5
   assign flags[7] = aux_q[`PIW_AUX_TIMER3];
   assign flags[8] = aux_q[`PIW_AUX_P1CHG];
   assign flags[9] = aux_q[`PIW_AUX_PIN2];
   assign flags[10] = aux_q[`PIW_AUX_ADC] | aux_q[`PIW_AUX_TOUCH]; // RULE4
   assign flags[11] = spi_flag_in;
   assign flags[12] = uart2_flag_in;

   // enable map by slot
   assign enables = {ien1_q[5], ien1_q[4], ien1_q[3], ien1_q[2], ien1_q[1], ien1_q[0], 1'b0,
                     ien0_q[5:0]}; // RULE13 RULE14 RULE12

   // level = {high, low} per slot
   assign levels = {prh1_q[5], prl1_q[5], prh1_q[4], prl1_q[4], prh1_q[3], prl1_q[3],
                    prh1_q[2], prl1_q[2], prh1_q[1], prl1_q[1], prh1_q[0], prl1_q[0], 2'b00,
                    prh0_q[5], prl0_q[5], prh0_q[4], prl0_q[4], prh0_q[3], prl0_q[3],
                    prh0_q[2], prl0_q[2], prh0_q[1], prl0_q[1], prh0_q[0], prl0_q[0]}; // RULE15 RULE16 RULE17

   // global enable blocks every request and the idle wake
   assign gated = flags & enables & {13{ien0_q[`PIW_BIT_GLOBAL_EN]}}; // RULE10 RULE1

   wire arb_grant;
   wire [3:0] arb_slot;
   wire [1:0] arb_level;

   // combinational winner, registered in the service block
   piw_arbiter u_arb (
      .req_in(gated),
      .level_in(levels),
      .active_in(active_q),
      .grant_out(arb_grant),
      .slot_out(arb_slot),
      .level_out(arb_level)
   );

   // core takes the presented vector
   assign ack_take = irq_ack_in & irq_req_out;
   assign p1_change_hit = |(p1_chg & port1_wake_mask_q);

   // ========================================================================
   // register writes and flag capture
   always @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         port1_wake_mask_q <= `PIW_RST_BYTE;
         ien0_q <= `PIW_RST_BYTE;
         ien1_q <= `PIW_RST_BYTE;
         prl0_q <= `PIW_RST_BYTE;
         prh0_q <= `PIW_RST_BYTE;
         prl1_q <= `PIW_RST_BYTE;
         prh1_q <= `PIW_RST_BYTE;
         aux_q <= `PIW_RST_BYTE;
      end else begin
         // address decode; one write per cycle at most
         if (wr_hit(`PIW_ADDR_P1WAKE)) begin
            port1_wake_mask_q <= sfr_wdata_in; // RULE9
         end else if (wr_hit(`PIW_ADDR_IEN0)) begin
            ien0_q <= sfr_wdata_in & `PIW_IEN0_MASK; // RULE13
         end else if (wr_hit(`PIW_ADDR_IEN1)) begin
            ien1_q <= sfr_wdata_in & `PIW_SIX_MASK; // RULE14
         end else if (wr_hit(`PIW_ADDR_PRL0)) begin
            prl0_q <= sfr_wdata_in & `PIW_SIX_MASK;
         end else if (wr_hit(`PIW_ADDR_PRH0)) begin
            prh0_q <= sfr_wdata_in & `PIW_SIX_MASK;
         end else if (wr_hit(`PIW_ADDR_PRL1)) begin
            prl1_q <= sfr_wdata_in & `PIW_SIX_MASK;
         end else if (wr_hit(`PIW_ADDR_PRH1)) begin
            prh1_q <= sfr_wdata_in & `PIW_SIX_MASK;
         end
         // aux flags: write zero clears, hardware set wins the same cycle
         // clears come first and sets are ORed last, so no event is lost
         aux_q <= (wr_hit(`PIW_ADDR_AUXFLG) ?
                   (aux_q & sfr_wdata_in) : aux_q) & `PIW_AUX_MASK // RULE21
                  & ~((ack_take && slot_q == 4'h8) ? 8'h02 : 8'h00)
                  & ~((ack_take && slot_q == 4'h9) ? 8'h04 : 8'h00) // RULE19
                  | {2'b00, touch_done_set_in, adc_done_set_in, 1'b0, p2_fall,
                     p1_change_hit, timer3_overflow_set_in}; // RULE2
      end
   end

   // ========================================================================
   // edge flags for pins 0 and 1; set beats the service clear
   always @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pin0_edge_flag_out <= 1'b0;
         pin1_edge_flag_out <= 1'b0;
      end else begin
         if (p0_fall) begin
            pin0_edge_flag_out <= 1'b1; // RULE2
         end else if (ack_take && slot_q == 4'h0) begin
            pin0_edge_flag_out <= 1'b0; // RULE19
         end
         if (p1_fall) begin
            pin1_edge_flag_out <= 1'b1; // RULE2
         end else if (ack_take && slot_q == 4'h2) begin
            pin1_edge_flag_out <= 1'b0; // RULE19
         end
      end
   end

   // ========================================================================
   // service tracking and vector request to the core
   // one bit per level: equal levels never nest
   // request drops for a cycle on every entry and return
   always @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         active_q <= 4'h0;
         slot_q <= 4'h0;
         irq_req_out <= 1'b0;
         irq_vector_out <= 16'h0000;
      end else begin
         if (ack_take) begin
            // enter service at the granted level
            active_q <= active_q | (4'h1 << levels[2*slot_q +: 2]); // RULE8
            irq_req_out <= 1'b0;
         end else if (reti_in) begin
            // return drops the highest active level, lower one resumes
            if (active_q[3]) begin
               active_q[3] <= 1'b0;
            end else if (active_q[2]) begin
               active_q[2] <= 1'b0;
            end else if (active_q[1]) begin
               active_q[1] <= 1'b0;
            end else begin
               active_q[0] <= 1'b0; // RULE8
            end
            irq_req_out <= 1'b0;
         end else begin
            // present the current winner, withdraw when it goes away
            irq_req_out <= arb_grant; // RULE6 RULE7
            slot_q <= arb_slot;
            irq_vector_out <= slot_vec(arb_slot); // RULE4
         end
      end
   end

   // ========================================================================
   // wake-up outputs and read data
   always @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         idle_wake_out <= 1'b0;
         stop_wake_out <= 1'b0;
         sfr_rdata_out <= 8'h00;
      end else begin
         idle_wake_out <= |gated; // RULE3 RULE20
         // pin enables give stop wake without global enable
         stop_wake_out <= (ien0_q[`PIW_BIT_PIN0_EN] & (~p0_lvl | pin0_edge_flag_out))
                        | (ien0_q[`PIW_BIT_PIN1_EN] & (~p1_lvl | pin1_edge_flag_out))
                        | (ien1_q[`PIW_BIT_PIN2_EN] & aux_q[`PIW_AUX_PIN2])
                        | p1_change_hit; // RULE3 RULE11 RULE12
         // stop wake skips the global enable: software may
         // want the wake without taking the interrupt
         // read data follows the address of the previous cycle
         if (sfr_addr_in == `PIW_ADDR_P1WAKE) begin
            sfr_rdata_out <= port1_wake_mask_q;
         end else if (sfr_addr_in == `PIW_ADDR_IEN0) begin
            sfr_rdata_out <= ien0_q;
         end else if (sfr_addr_in == `PIW_ADDR_IEN1) begin
            sfr_rdata_out <= ien1_q;
         end else if (sfr_addr_in == `PIW_ADDR_PRL0) begin
            sfr_rdata_out <= prl0_q;
         end else if (sfr_addr_in == `PIW_ADDR_PRH0) begin
            sfr_rdata_out <= prh0_q;
         end else if (sfr_addr_in == `PIW_ADDR_PRL1) begin
            sfr_rdata_out <= prl1_q;
         end else if (sfr_addr_in == `PIW_ADDR_PRH1) begin
            sfr_rdata_out <= prh1_q;
         end else if (sfr_addr_in == `PIW_ADDR_AUXFLG) begin
            sfr_rdata_out <= aux_q;
         end else begin
            sfr_rdata_out <= 8'h00;
         end
      end
   end

endmodule

// File: core/piw_consts.vh
/*
 * constants for the prioritised interrupt and wake controller: special
 * register addresses, enable and aux flag bit positions, vector layout and
 * reset values.
 * assumes it is included by bare name from the core/ design files.
 */
`ifndef PIW_CONSTS_VH
`define PIW_CONSTS_VH

// ==========================================================================
// register addresses on the core special register port
`define PIW_ADDR_P1WAKE 8'h96
`define PIW_ADDR_IEN0 8'hA8
`define PIW_ADDR_IEN1 8'hA9
`define PIW_ADDR_PRL0 8'hB8
`define PIW_ADDR_PRH0 8'hB9
`define PIW_ADDR_PRL1 8'hBA
`define PIW_ADDR_PRH1 8'hBB
`define PIW_ADDR_AUXFLG 8'h95

// ==========================================================================
// field positions
`define PIW_BIT_GLOBAL_EN 7
`define PIW_BIT_PIN0_EN 0
`define PIW_BIT_PIN1_EN 2
`define PIW_BIT_PIN2_EN 2
`define PIW_BIT_P1CHG_EN 1
`define PIW_AUX_TIMER3 0
`define PIW_AUX_P1CHG 1
`define PIW_AUX_PIN2 2
`define PIW_AUX_ADC 4
`define PIW_AUX_TOUCH 5

// writable masks, unused bits read zero
`define PIW_IEN0_MASK 8'hBF
`define PIW_SIX_MASK 8'h3F
`define PIW_AUX_MASK 8'h37

// reset values
`define PIW_RST_BYTE 8'h00

// ==========================================================================
// vectors: base plus slot times spacing; slot 6 belongs to the emulator
`define PIW_VEC_BASE 16'h0003
`define PIW_VEC_STEP 8
`define PIW_SLOT_RESERVED 4'h6
`define PIW_NUM_SLOTS 13

`endif

// File: core/piw_edge_sync.v
/*
 * two flip-flop synchroniser for one pin plus falling and any-change
 * detection on the synchronised level.
 * assumes the pin is asynchronous to core_clk_in.
 */
`include "piw_consts.vh"

module piw_edge_sync (
   input wire core_clk_in,
   input wire reset_in,
   input wire pin_in,
   output wire level_out,
   output wire fall_out,
   output wire change_out
);

   // ========================================================================
   // synchroniser; first stage feeds only the second
   reg meta_q; // first stage
   reg sync_q; // second stage
   reg last_q; // previous synchronised level

   // reset high: idle pin level
   always @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level_out = sync_q;
   assign fall_out = last_q & ~sync_q;
   assign change_out = last_q ^ sync_q;

endmodule

// File: core/piw_arbiter.v
/*
 * level arbiter: picks the winning slot among enabled requests and tells
 * whether it may preempt the services now active.
 * assumes purely combinational use inside the controller top.
 */
`include "piw_consts.vh"

module piw_arbiter (
   input wire [12:0] req_in,
   input wire [25:0] level_in,
   input wire [3:0] active_in,
   output reg grant_out,
   output reg [3:0] slot_out,
   output reg [1:0] level_out
);

   // ========================================================================
   // search; lowest slot wins among equal levels
   integer i;
   integer l;
   reg found;

   always @* begin
      grant_out = 1'b0;
      slot_out = 4'h0;
      level_out = 2'h0;
      found = 1'b0;
      // scan highest level first, then lowest slot
      for (l = 3; l >= 0; l = l - 1) begin
         for (i = 0; i < `PIW_NUM_SLOTS; i = i + 1) begin
            if (!found && req_in[i] && level_in[2*i +: 2] == l[1:0]) begin // RULE18
               found = 1'b1;
               slot_out = i[3:0];
               level_out = l[1:0];
            end
         end
      end
      // grant only when no equal or higher service is active
      grant_out = found && (active_in >> level_out) == 4'h0; // RULE6 RULE7 RULE8
   end

endmodule

// File: tb/piw_ctrl_properties.sv
/* checker for the interrupt and wake controller: port-level properties.
   assumes it is bound to piw_ctrl and sees only that module's ports. */
module piw_ctrl_properties (
   input wire core_clk_in,
   input wire reset_in,
   input wire [7:0] sfr_addr_in,
   input wire sfr_wr_in,
   input wire [7:0] sfr_wdata_in,
   input wire [7:0] sfr_rdata_out,
   input wire irq_ack_in,
   input wire irq_req_out,
   input wire [15:0] irq_vector_out,
   input wire idle_wake_out,
   input wire stop_wake_out,
   input wire pin0_edge_flag_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // ======================================
   // shadows of enables, rebuilt from register writes
   reg [7:0] ien0_q;
   reg [7:0] ien1_q;
   reg [7:0] p1w_q;
   // any stop wake source enabled at all
   wire wake_src = ien0_q[0] | ien0_q[2] | ien1_q[2] | (|p1w_q);
   always @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ien0_q <= 8'h00;
         ien1_q <= 8'h00;
         p1w_q <= 8'h00;
      end else if (sfr_wr_in) begin
         // unused bits masked as the design reads them back
         if (sfr_addr_in == 8'hA8) ien0_q <= sfr_wdata_in & 8'hBF;
         if (sfr_addr_in == 8'hA9) ien1_q <= sfr_wdata_in & 8'h3F;
         if (sfr_addr_in == 8'h96) p1w_q <= sfr_wdata_in;
      end
   end
   // ======================================
   // two cycles of margin: outputs are registered from registers
   a_global_blocks_req: assert property (!ien0_q[7] && !$past(ien0_q[7]) |-> !irq_req_out)
      else $error("request raised with global enable off");
   a_vector_on_grid: assert property (irq_req_out |-> irq_vector_out[2:0] == 3'h3 && irq_vector_out <= 16'h0063)
      else $error("vector off the grid");
   a_reserved_slot: assert property (irq_req_out |-> irq_vector_out != 16'h0033)
      else $error("reserved vector presented");
   a_enable_readback: assert property ($past(sfr_addr_in) == 8'hA8 && !$past(sfr_wr_in) |-> sfr_rdata_out == ien0_q)
      else $error("enable register read back wrong");
   a_ack_same_level: assert property (irq_req_out && irq_ack_in |=> !irq_req_out || irq_vector_out != $past(irq_vector_out))
      else $error("acknowledged request presented again");
   a_idle_needs_global: assert property (idle_wake_out |-> ien0_q[7] || $past(ien0_q[7]))
      else $error("idle wake without global enable");
   a_stop_needs_enable: assert property (!wake_src && !$past(wake_src) |-> !stop_wake_out)
      else $error("stop wake with no wake source enabled");
   a_pin0_flag_clear: assert property (irq_req_out && irq_ack_in && irq_vector_out == 16'h0003 |=> !pin0_edge_flag_out)
      else $error("pin0 edge flag kept after service entry");
endmodule

bind piw_ctrl piw_ctrl_properties chk_u (.core_clk_in, .reset_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
   .sfr_rdata_out, .irq_ack_in, .irq_req_out, .irq_vector_out, .idle_wake_out, .stop_wake_out, .pin0_edge_flag_out);

// File: tb/piw_core_model.sv
/* processor core model: takes vectors, services, returns, nesting up to four.
   assumes the controller presents a registered request and vector. */
module piw_core_model (
   input wire core_clk_in,
   input wire reset_in,
   input wire irq_req_in,
   input wire hold_in,
   input wire [7:0] svc_len_in,
   output logic ack_out,
   output logic reti_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ======================================
   int depth;
   int left [4];
   // drives off the falling edge; hold_in stalls acceptance to model a slow core
   always @(negedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ack_out <= 1'b0;
         reti_out <= 1'b0;
         depth <= 0;
      end else begin
         ack_out <= 1'b0;
         reti_out <= 1'b0;
         // guard on ack_out: request drops only one edge after the ack
         if (irq_req_in && !ack_out && !hold_in && depth < 4) begin
            ack_out <= 1'b1;
            left[depth] <= svc_len_in;
            depth <= depth + 1;
         end else if (depth > 0) begin
            // only the innermost service runs; outer ones resume later
            if (left[depth-1] == 0) begin
               reti_out <= 1'b1;
               depth <= depth - 1;
            end else begin
               left[depth-1] <= left[depth-1] - 1;
            end
         end
      end
   end
endmodule

// File: tb/piw_ctrl_tb_top.sv
/* self-checking bench for the interrupt and wake controller.
   assumes piw_ctrl, its checker and the core model are compiled before it. */
module piw_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wr = 0, hold = 0, p0 = 1, t3s = 0, ads = 0, tks = 0, m1 = 1, e1 = 1, e2 = 1;
   logic [7:0] addr = 0, wdata = 0, p1 = 0, rdata, r;
   logic [5:0] lv = 0; // t0, t1, uart1, t2, spi, uart2 flag levels
   logic req, ack, reti, iw, sw, f0, f1;
   logic [15:0] vec;
   logic [15:0] acked [$];
   int fail_count = 0, compares = 0, rets = 0, n;
   logic [7:0] ra [7] = '{8'h96, 8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hBA, 8'hBB};
   logic [7:0] rm [7] = '{8'hFF, 8'hBF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
   logic [15:0] vt [6] = '{16'h000B, 16'h001B, 16'h0023, 16'h002B, 16'h005B, 16'h0063};
   logic [7:0] eb [6] = '{8'h02, 8'h08, 8'h10, 8'h20, 8'h10, 8'h20};
   always #5 clk = ~clk;
   // ======================================
   piw_ctrl dut_u (.core_clk_in(clk), .reset_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
      .sfr_rdata_out(rdata), .ext_pin0_in(p0), .ext_pin1_in(e1), .ext_pin2_in(e2), .port1_pins_in(p1),
      .pin0_edge_mode_in(1'b1), .pin1_edge_mode_in(m1), .timer0_overflow_flag_in(lv[0]),
      .timer1_overflow_flag_in(lv[1]), .uart1_flag_in(lv[2]), .timer2_flag_in(lv[3]), .spi_flag_in(lv[4]),
      .uart2_flag_in(lv[5]), .timer3_overflow_set_in(t3s), .adc_done_set_in(ads), .touch_done_set_in(tks),
      .irq_ack_in(ack), .reti_in(reti), .irq_req_out(req), .irq_vector_out(vec), .idle_wake_out(iw),
      .stop_wake_out(sw), .pin0_edge_flag_out(f0), .pin1_edge_flag_out(f1));
   piw_core_model core_u (.core_clk_in(clk), .reset_in(rst), .irq_req_in(req), .hold_in(hold),
      .svc_len_in(8'd30), .ack_out(ack), .reti_out(reti));
   // log every vector the core takes and every return
   always @(posedge clk) begin
      if (req && ack) acked.push_back(vec);
      if (reti) rets++;
   end
   // ======================================
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
   endtask
   // read data is registered: look one cycle after the address
   task automatic get(input logic [7:0] a, input logic [7:0] e, input string what);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      chk(rdata, e, what);
   endtask
   task automatic exp_ack(input int k, input logic [15:0] v);
      int i;
      i = 0;
      while (acked.size() < k && i < 300) begin
         @(negedge clk);
         i++;
      end
      if (acked.size() >= k) chk(acked[k-1], v, "vector");
      else chk(16'hFFFF, v, "no acknowledge");
   endtask
   // wait until every taken service has returned
   task automatic quiet;
      int i;
      i = 0;
      while (rets < acked.size() && i < 400) begin
         @(negedge clk);
         i++;
      end
      chk(16'(rets), 16'(acked.size()), "returns");
   endtask
   task automatic test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end
   // ======================================
   initial begin
      void'($urandom(84117));
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 0;
      // registers: reset value, random write, masked read back
      for (int i = 0; i < 7; i++) begin
         r = $urandom;
         get(ra[i], 8'h00, "reset value");
         put(ra[i], r);
         get(ra[i], r & rm[i], "read back");
         put(ra[i], 8'h00);
      end
      put(8'h90, 8'hFF);
      get(8'h90, 8'h00, "unmapped");
      $display("test registers done");
      // held flags set with enables off; write one keeps, zero clears
      @(negedge clk);
      {t3s, ads, tks} = 3'b111;
      @(negedge clk);
      {t3s, ads, tks} = 3'b000;
      get(8'h95, 8'h31, "aux set");
      put(8'h95, 8'hFF);
      get(8'h95, 8'h31, "aux keep");
      n = acked.size();
      put(8'hA9, 8'h09);
      put(8'hA8, 8'h80);
      exp_ack(n + 1, 16'h003B);
      put(8'h95, 8'hFE);
      get(8'h95, 8'h30, "aux clear");
      exp_ack(n + 2, 16'h0053);
      put(8'h95, 8'h00);
      quiet();
      $display("test aux flags done");
      // every level source: blocked by global enable, then its vector
      for (int i = 0; i < 6; i++) begin
         put(8'hA8, i < 4 ? eb[i] : 8'h00);
         put(8'hA9, i < 4 ? 8'h00 : eb[i]);
         n = acked.size();
         @(negedge clk);
         lv[i] = 1;
         repeat (4) @(negedge clk);
         chk(req, 0, "global off");
         chk(iw, 0, "idle wake global off");
         put(8'hA8, (i < 4 ? eb[i] : 8'h00) | 8'h80);
         exp_ack(n + 1, vt[i]);
         lv[i] = 0;
         quiet();
      end
      $display("test vectors done");
      // t1 level 01, uart2 level 10, t0 and t2 level 00
      put(8'hB8, 8'h08);
      put(8'hBB, 8'h20);
      put(8'hA9, 8'h20);
      hold = 1;
      put(8'hA8, 8'hAA);
      n = acked.size();
      @(negedge clk);
      lv[0] = 1;
      lv[3] = 1;
      repeat (4) @(negedge clk);
      chk(vec, 16'h000B, "equal level order");
      chk(iw, 1, "idle wake");
      hold = 0;
      exp_ack(n + 1, 16'h000B);
      lv[0] = 0;
      repeat (3) @(negedge clk);
      chk(req, 0, "equal level waits");
      lv[1] = 1;
      exp_ack(n + 2, 16'h001B);
      lv[1] = 0;
      lv[5] = 1;
      exp_ack(n + 3, 16'h0063);
      lv[5] = 0;
      exp_ack(n + 4, 16'h002B);
      lv[3] = 0;
      quiet();
      put(8'hB8, 8'h00);
      put(8'hBB, 8'h00);
      put(8'hA9, 8'h00);
      put(8'hA8, 8'h01);
      $display("test nesting done");
      // pin0: flag and stop wake with global enable off
      @(negedge clk);
      p0 = 0;
      repeat (8) @(negedge clk);
      chk(f0, 1, "pin0 flag");
      chk(sw, 1, "pin0 stop wake");
      chk(req, 0, "pin0 global off");
      n = acked.size();
      put(8'hA8, 8'h81);
      exp_ack(n + 1, 16'h0003);
      p0 = 1;
      @(negedge clk);
      chk(f0, 0, "pin0 flag cleared");
      quiet();
      // port1: only masked pins flag; change enable gates service only
      put(8'h96, 8'h01);
      p1 = 8'h02;
      repeat (8) @(negedge clk);
      get(8'h95, 8'h00, "unmasked pin");
      p1 = 8'h03;
      repeat (8) @(negedge clk);
      get(8'h95, 8'h02, "masked pin");
      chk(req, 0, "change enable off");
      put(8'hA9, 8'h02);
      exp_ack(n + 2, 16'h0043);
      get(8'h95, 8'h00, "change flag cleared");
      quiet();
      // pin1 low level and pin2 edge: lower slot first
      m1 = 0;
      put(8'hA9, 8'h04);
      put(8'hA8, 8'h84);
      n = acked.size();
      {e1, e2} = 2'b00;
      exp_ack(n + 1, 16'h0013);
      {e1, e2} = 2'b11;
      chk(f1, 0, "pin1 flag cleared");
      exp_ack(n + 2, 16'h004B);
      get(8'h95, 8'h00, "pin2 flag cleared");
      quiet();
      $display("test pins done");
      test_done();
   end
endmodule
